// ===== logic/serial_cfg.svh
// Purpose: constants for the serial receive/transmit flag block
// Assumes: 100 MHz clk_sys, one bit time counted in whole clock cycles
// Notes: the bit-time count here is a default; the top exposes it as the BIT_CLKS parameter
`ifndef SERIAL_CFG_SVH
`define SERIAL_CFG_SVH

// clock and line rate
`define CFG_CLK_HZ 100000000
`define CFG_BAUD_HZ 9600
`define CFG_BIT_CLKS (`CFG_CLK_HZ / `CFG_BAUD_HZ)
`define CFG_TIMER_W 16

// frame lengths in bit times, start and stop included
`define CFG_FRAME8_LEN 4'd10
`define CFG_FRAME9_LEN 4'd11
`define CFG_DATA8_BITS 4'd8
`define CFG_DATA9_BITS 4'd9

// reset values of the flags
`define CFG_TX_EMPTY_RST 1'b1
`define CFG_TX_DONE_RST 1'b1
`define CFG_RX_FULL_RST 1'b0

`endif

// ===== logic/serial_pkg.sv
// Purpose: types shared by the serial flag block
// Assumes: nothing beyond the cfg header
// Notes: control and status travel as packed structs
package serial_pkg;

	// software-set control bits
	typedef struct packed {
		logic rx_char9;
		logic tx_enable;
		logic tx_empty_irq_enable;
		logic tx_done_irq_enable;
		logic rx_full_irq_enable;
	} ctrl_t;

	// status flags shown to software
	typedef struct packed {
		logic tx_buffer_empty_flag;
		logic tx_done_flag;
		logic rx_full_flag;
	} status_t;

	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
	typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} tx_state_t;

endpackage

// ===== logic/bit_timer.sv
// Purpose: bit-time counter giving one-cycle ticks
// Assumes: period and first_len are at least one
// Notes: start reloads with first_len, later ticks every period cycles
`timescale 1ns/10ps
module bit_timer #(
	parameter int W = 16
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// control
	input wire logic run,
	input wire logic start,
	input wire logic [W-1:0] first_len,
	input wire logic [W-1:0] period,
	// event
	output logic tick
);

	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;

	// tick when the count runs out, never in the start cycle
	assign tick = run && !start && (cnt_q == '0);
	assign cnt_d = start ? first_len - W'(1) :
		!run ? '0 :
		(cnt_q == '0) ? period - W'(1) : cnt_q - W'(1);

	// counter register
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

endmodule

// ===== logic/serial_rx_tx.sv
// Purpose: serial receiver and transmitter flags with interrupt requests
// Assumes: control bits and strobes come from clk_sys logic; rxd is async
// Notes: outputs are registered, so requests trail their flags by one cycle
`timescale 1ns/10ps
`include "serial_cfg.svh"
module serial_rx_tx
	import serial_pkg::*;
#(
	parameter int BIT_CLKS = `CFG_BIT_CLKS
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// control from software
	input wire ctrl_t ctrl,
	input wire logic send_break,
	input wire logic send_idle,
	// transmit data write
	input wire logic tx_wr,
	input wire logic [8:0] tx_wdata,
	// receive data read
	input wire logic rx_rd,
	output logic [7:0] data_buffer_reg,
	output logic ninth_data_bit,
	// status and requests
	output status_t status_reg_one,
	output logic tx_irq,
	output logic rx_irq,
	// serial pins
	input wire logic rxd,
	output logic txd
);

	localparam int TW = `CFG_TIMER_W;
	localparam logic [TW-1:0] BIT_LEN = TW'(BIT_CLKS);
	localparam logic [TW-1:0] HALF_LEN = TW'((BIT_CLKS + 1) / 2);

	// receive side state
	logic rx_meta_q, rx_sync_q;
	rx_state_t rx_state_q, rx_state_d;
	logic [8:0] rx_shift_q;
	logic [3:0] rx_cnt_q;
	logic rx_char9_q;
	logic rx_full_q;
	logic [7:0] rx_data_q;
	logic rx_ninth_q;
	logic rx_tick, rx_start_tmr, rx_run;
	logic rx_done;
	logic [3:0] rx_bits;

	// transmit side state
	tx_state_t tx_state_q;
	logic [8:0] tx_buf_q;
	logic tx_empty_q;
	logic tx_done_q;
	logic [10:0] tx_frame_q;
	logic [3:0] tx_left_q;
	logic tx_special_q;
	logic idle_pend_q;
	logic txd_q;
	logic tx_irq_q, rx_irq_q;
	logic tx_tick, tx_busy, tx_load_data, tx_load_idle, tx_load_break, tx_load;
	logic tx_last;
	logic tx_done_d;
	logic [10:0] frame8, frame9;

	// pin synchroniser, only the second stage is read
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rx_meta_q <= 1'b1;
			rx_sync_q <= 1'b1;
		end else begin
			rx_meta_q <= rxd;
			rx_sync_q <= rx_meta_q;
		end
	end

	// receive bit timing: half bit to centre the start bit, then whole bits
	bit_timer #(.W(TW)) u_rx_timer (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.run(rx_run),
		.start(rx_start_tmr),
		.first_len(HALF_LEN),
		.period(BIT_LEN),
		.tick(rx_tick)
	);

	// length latched at start so a mid-character change cannot tear it
	assign rx_bits = rx_char9_q ? `CFG_DATA9_BITS : `CFG_DATA8_BITS;
	assign rx_start_tmr = (rx_state_q == RX_IDLE) && !rx_sync_q;
	assign rx_run = (rx_state_q != RX_IDLE);
	// transfer only at the stop bit, once the character is complete
	assign rx_done = (rx_state_q == RX_STOP) && rx_tick;

	// receive sequence
	always_comb begin
		rx_state_d = rx_state_q;
		case (rx_state_q)
			RX_IDLE: begin
				if (!rx_sync_q) rx_state_d = RX_START;
			end
			RX_START: begin
				// a start bit that is high again at its centre was a glitch
				if (rx_tick) rx_state_d = rx_sync_q ? RX_IDLE : RX_DATA;
			end
			RX_DATA: begin
				if (rx_tick && (rx_cnt_q == rx_bits - 4'd1)) rx_state_d = RX_STOP;
			end
			RX_STOP: begin
				if (rx_tick) rx_state_d = RX_IDLE;
			end
			default: rx_state_d = RX_IDLE;
		endcase
	end

	// receive state and shift register
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rx_state_q <= RX_IDLE;
			rx_shift_q <= 9'h000;
			rx_cnt_q <= 4'h0;
			rx_char9_q <= 1'b0;
		end else begin
			rx_state_q <= rx_state_d;
			if (rx_start_tmr) rx_char9_q <= ctrl.rx_char9;
			if (rx_state_q != RX_DATA) rx_cnt_q <= 4'h0;
			// lsb arrives first and walks down from the top
			else if (rx_tick) begin
				rx_shift_q <= {rx_sync_q, rx_shift_q[8:1]};
				rx_cnt_q <= rx_cnt_q + 4'd1;
			end
		end
	end

	// buffer only ever loaded from the shifter, never by software
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rx_data_q <= 8'h00;
			rx_ninth_q <= 1'b0;
		end else if (rx_done) begin
			rx_data_q <= rx_char9_q ? rx_shift_q[7:0] : rx_shift_q[8:1];
			// top bit is bit 8 in nine-bit mode, bit 7 in eight-bit mode
			rx_ninth_q <= rx_shift_q[8];
		end
	end

	// full flag set by transfer; set wins over a read in the same cycle
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rx_full_q <= `CFG_RX_FULL_RST;
		end else if (rx_done) begin
			rx_full_q <= 1'b1;
		end else if (rx_rd) begin
			rx_full_q <= 1'b0;
		end
	end

	// transmit bit timing, first tick one cycle after the load
	bit_timer #(.W(TW)) u_tx_timer (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.run(tx_busy),
		.start(tx_load),
		.first_len(TW'(1)),
		.period(BIT_LEN),
		.tick(tx_tick)
	);

	// transmit frame selection: break first, then queued idle, then data
	assign tx_busy = (tx_state_q == TX_SHIFT);
	assign tx_load_break = !tx_busy && ctrl.tx_enable && send_break;
	assign tx_load_idle = !tx_busy && ctrl.tx_enable && !send_break && idle_pend_q;
	assign tx_load_data = !tx_busy && ctrl.tx_enable && !send_break && !idle_pend_q &&
		!tx_empty_q;
	assign tx_load = tx_load_break || tx_load_idle || tx_load_data;
	assign tx_last = tx_tick && (tx_left_q == 4'h0);
	assign frame8 = {2'b11, tx_buf_q[7:0], 1'b0};
	assign frame9 = {1'b1, tx_buf_q[8:0], 1'b0};

	// shifter: outputs frame lsb first, ends after the last full bit time
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			tx_state_q <= TX_IDLE;
			tx_frame_q <= 11'h7ff;
			tx_left_q <= 4'h0;
			tx_special_q <= 1'b0;
			txd_q <= 1'b1;
		end else begin
			case (tx_state_q)
				TX_IDLE: begin
					txd_q <= 1'b1;
					if (tx_load) begin
						tx_state_q <= TX_SHIFT;
						tx_special_q <= !tx_load_data;
						tx_left_q <= ctrl.rx_char9 ? `CFG_FRAME9_LEN : `CFG_FRAME8_LEN;
						tx_frame_q <= tx_load_break ? 11'h000 : tx_load_idle ? 11'h7ff :
							ctrl.rx_char9 ? frame9 : frame8;
					end
				end
				TX_SHIFT: begin
					if (tx_last) begin
						tx_state_q <= TX_IDLE;
						tx_special_q <= 1'b0;
						txd_q <= 1'b1;
					end else if (tx_tick) begin
						txd_q <= tx_frame_q[0];
						tx_frame_q <= {1'b1, tx_frame_q[10:1]};
						tx_left_q <= tx_left_q - 4'd1;
					end
				end
				default: tx_state_q <= TX_IDLE;
			endcase
		end
	end

	// buffer and empty flag; a write clears, handover sets
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			tx_buf_q <= 9'h000;
			tx_empty_q <= `CFG_TX_EMPTY_RST;
			idle_pend_q <= 1'b0;
		end else begin
			if (tx_wr) tx_buf_q <= tx_wdata;
			// a write landing with the handover holds new data, so not empty
			if (tx_wr) tx_empty_q <= 1'b0;
			// empty once the buffer has gone to the shifter
			else if (tx_load_data) tx_empty_q <= 1'b1;
			// queued idle request survives until its frame is loaded
			if (send_idle) idle_pend_q <= 1'b1;
			else if (tx_load_idle) idle_pend_q <= 1'b0;
		end
	end

	// done only when shifter and buffer idle, nothing written, no break or idle
	assign tx_done_d = tx_empty_q && !tx_wr && !tx_busy && !tx_load && !idle_pend_q &&
		!send_break && !tx_special_q;

	// flag and request registers
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			tx_done_q <= `CFG_TX_DONE_RST;
			tx_irq_q <= 1'b0;
			rx_irq_q <= 1'b0;
		end else begin
			tx_done_q <= tx_done_d;
			// each source gated by its enable, then ORed as a level
			tx_irq_q <= (tx_empty_q && ctrl.tx_empty_irq_enable) ||
				(tx_done_q && ctrl.tx_done_irq_enable);
			// receive request follows the full flag while enabled
			rx_irq_q <= rx_full_q && ctrl.rx_full_irq_enable;
		end
	end

	// registered outputs
	assign data_buffer_reg = rx_data_q;
	assign ninth_data_bit = rx_ninth_q;
	assign status_reg_one = '{tx_buffer_empty_flag: tx_empty_q, tx_done_flag: tx_done_q,
		rx_full_flag: rx_full_q};
	assign tx_irq = tx_irq_q;
	assign rx_irq = rx_irq_q;
	assign txd = txd_q;

endmodule

// ===== verif/serial_rx_tx_monitor.sv
// Purpose: port-level checks of the serial flag block
// Assumes: one clock domain, async active-low reset
// Notes: requests are registered, so they trail flags by one cycle
`timescale 1ns/10ps
module serial_rx_tx_monitor
	import serial_pkg::*;
#(
	parameter int BIT_CLKS = 16
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// control and strobes
	input wire ctrl_t ctrl,
	input wire logic send_break,
	input wire logic send_idle,
	input wire logic tx_wr,
	input wire logic [8:0] tx_wdata,
	input wire logic rx_rd,
	// results
	input wire logic [7:0] data_buffer_reg,
	input wire logic ninth_data_bit,
	input wire status_t status_reg_one,
	input wire logic tx_irq,
	input wire logic rx_irq,
	input wire logic rxd,
	input wire logic txd
);
	logic full, empty, done;
	// short names for the flags
	assign full = status_reg_one.rx_full_flag;
	assign empty = status_reg_one.tx_buffer_empty_flag;
	assign done = status_reg_one.tx_done_flag;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	// a write makes the buffer busy on the next edge
	sequence s_write;
		tx_wr ##1 !empty;
	endsequence
	write_busy_a: assert property (tx_wr |-> s_write)
		else $error("buffer not busy after write");
	empty_fall_a: assert property ($fell(empty) |-> $past(tx_wr))
		else $error("empty flag fell without a write");
	tx_irq_or_a: assert property (tx_irq == $past(empty & ctrl.tx_empty_irq_enable
		| done & ctrl.tx_done_irq_enable))
		else $error("transmit request wrong");
	// receive request follows enabled full flag
	rx_irq_follow_a: assert property (rx_irq == $past(full & ctrl.rx_full_irq_enable))
		else $error("receive request wrong");
	done_rise_a: assert property (done |-> empty)
		else $error("done set with buffer full");
	done_idle_a: assert property (done |-> txd)
		else $error("line active while done");
	// buffer loads with the full flag
	load_full_a: assert property ($changed(data_buffer_reg) |-> full)
		else $error("buffer changed without full flag");
	// ninth bit loads with the buffer
	ninth_full_a: assert property ($changed(ninth_data_bit) |-> full)
		else $error("ninth bit changed without full flag");
	// full flag clears only on a read
	full_clear_a: assert property ($fell(full) |-> $past(rx_rd))
		else $error("full flag cleared without read");
endmodule

// ===== verif/serial_peer.sv
// Purpose: remote serial peer: drives the receive pin, samples the transmit pin
// Assumes: bit time in whole clk_sys cycles
// Notes: always sends eleven bit times; in eight-bit mode the extra one is idle
`timescale 1ns/10ps
module serial_peer #(
	parameter int BIT_CLKS = 16
) (
	// clock
	input wire logic clk_sys,
	// serial lines
	input wire logic txd,
	output logic rxd
);
	initial rxd = 1'b1;
	// start low, lsb first, stop high
	task automatic send(input logic [8:0] d, input logic nine);
		logic [10:0] f;
		f = nine ? {1'b1, d, 1'b0} : {2'b11, d[7:0], 1'b0};
		for (int i = 0; i < 11; i++) begin
			@(posedge clk_sys);
			rxd <= f[i];
			repeat (BIT_CLKS - 1) @(posedge clk_sys);
		end
	endtask
	// far receiver: find the start bit, then sample each bit at its centre
	task automatic recv(input logic nine, output logic [8:0] d, output logic ok);
		int i;
		d = 9'h000;
		for (i = 0; i < 4 * BIT_CLKS && txd !== 1'b0; i++) @(posedge clk_sys);
		ok = (i < 4 * BIT_CLKS);
		repeat (BIT_CLKS / 2) @(posedge clk_sys);
		for (int b = 0; b < 9; b++) begin
			repeat (BIT_CLKS) @(posedge clk_sys);
			if (b < 8 || nine) d[b] = txd;
		end
	endtask
endmodule

// ===== verif/tb_serial_rx_tx.sv
// Purpose: self-checking bench for the serial flag block
// Assumes: short bit time to keep the run brief
// Notes: expected receive values come from a queue model
`timescale 1ns/10ps
module tb_serial_rx_tx;
	import serial_pkg::*;
	localparam int BIT = 16;
	logic clk_sys, rst_b, send_break, send_idle, tx_wr, rx_rd, rxd, txd;
	logic tx_irq, rx_irq, ninth_data_bit;
	logic [8:0] tx_wdata, d;
	logic [7:0] data_buffer_reg;
	ctrl_t ctrl;
	status_t status_reg_one;
	int mismatches, n_tests;
	logic [8:0] exp_q[$];
	serial_peer #(.BIT_CLKS(BIT)) u_peer (.clk_sys(clk_sys), .txd(txd), .rxd(rxd));
	serial_rx_tx #(.BIT_CLKS(BIT)) u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .ctrl(ctrl),
		.send_break(send_break), .send_idle(send_idle), .tx_wr(tx_wr), .tx_wdata(tx_wdata),
		.rx_rd(rx_rd), .data_buffer_reg(data_buffer_reg), .ninth_data_bit(ninth_data_bit),
		.status_reg_one(status_reg_one), .tx_irq(tx_irq), .rx_irq(rx_irq), .rxd(rxd),
		.txd(txd));
	// free-running clock
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("mismatches %0d n_tests %0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// bounded wait, a hang ends the run
	task automatic wait_flag(input int idx, input logic v);
		int i;
		for (i = 0; i < 400; i++) begin
			@(posedge clk_sys);
			#1;
			if (status_reg_one[idx] === v) break;
		end
		if (i == 400) begin
			mismatches++;
			final_report();
		end
	endtask
	// one received character, then a read
	task automatic rx_char(input logic nine, input logic ie);
		@(posedge clk_sys);
		ctrl.rx_char9 <= nine;
		ctrl.rx_full_irq_enable <= ie;
		d = 9'($urandom);
		exp_q.push_back(nine ? d : {d[7], d[7:0]});
		u_peer.send(d, nine);
		wait_flag(0, 1'b1);
		d = exp_q.pop_front();
		check(9'(data_buffer_reg), {1'b0, d[7:0]});
		check(9'(ninth_data_bit), 9'(d[8]));
		check(9'(rx_irq), 9'(ie));
		@(posedge clk_sys);
		rx_rd <= 1'b1;
		@(posedge clk_sys);
		rx_rd <= 1'b0;
		#1;
		check(9'(status_reg_one.rx_full_flag), 9'h0);
	endtask
	// one transmitted character with chosen enables
	task automatic tx_char(input logic ee, input logic de);
		logic [8:0] got;
		logic ok;
		@(posedge clk_sys);
		ctrl.rx_char9 <= ee ^ de;
		ctrl.tx_enable <= 1'b1;
		ctrl.tx_empty_irq_enable <= ee;
		ctrl.tx_done_irq_enable <= de;
		d = 9'($urandom);
		tx_wdata <= d;
		tx_wr <= 1'b1;
		@(posedge clk_sys);
		tx_wr <= 1'b0;
		#1;
		check(9'(status_reg_one.tx_buffer_empty_flag), 9'h0);
		wait_flag(2, 1'b1);
		repeat (2) @(posedge clk_sys);
		#1;
		check(9'(status_reg_one.tx_done_flag), 9'h0);
		check(9'(tx_irq), 9'(ee));
		u_peer.recv(ee ^ de, got, ok);
		check(9'(ok), 9'h1);
		check(got, (ee ^ de) ? d : {1'b0, d[7:0]});
		wait_flag(1, 1'b1);
		@(posedge clk_sys);
		#1;
		check(9'(tx_irq), 9'(ee | de));
	endtask
	// main sequence
	initial begin
		d = 9'($urandom(32'h75cab379));
		{rst_b, send_break, send_idle, tx_wr, rx_rd} = '0;
		ctrl = '0;
		tx_wdata = '0;
		repeat (3) @(posedge clk_sys);
		rst_b <= 1'b1;
		#1;
		check(9'(status_reg_one), 9'h6);
		check(9'(txd), 9'h1);
		for (int k = 0; k < 4; k++) rx_char(k[0], k[1]);
		for (int k = 0; k < 4; k++) tx_char(k[0], k[1]);
		// break held, then one queued idle
		@(posedge clk_sys);
		send_break <= 1'b1;
		repeat (40) @(posedge clk_sys);
		send_break <= 1'b0;
		#1;
		check(9'(status_reg_one.tx_done_flag), 9'h0);
		wait_flag(1, 1'b1);
		@(posedge clk_sys);
		send_idle <= 1'b1;
		@(posedge clk_sys);
		send_idle <= 1'b0;
		repeat (2) @(posedge clk_sys);
		#1;
		check(9'(status_reg_one.tx_done_flag), 9'h0);
		wait_flag(1, 1'b1);
		final_report();
	end
endmodule
bind serial_rx_tx serial_rx_tx_monitor #(.BIT_CLKS(BIT_CLKS)) u_mon (.clk_sys(clk_sys),
	.rst_b(rst_b), .ctrl(ctrl), .send_break(send_break), .send_idle(send_idle), .tx_wr(tx_wr),
	.tx_wdata(tx_wdata), .rx_rd(rx_rd), .data_buffer_reg(data_buffer_reg),
	.ninth_data_bit(ninth_data_bit), .status_reg_one(status_reg_one), .tx_irq(tx_irq),
	.rx_irq(rx_irq), .rxd(rxd), .txd(txd));
